// ### hw/sfo_fifo.sv
`default_nettype none
module sfo_fifo #(
	parameter int unsigned DEPTH = 256
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// Write side
	input  wire logic                       write_enable_n,
	input  wire logic [sfo_pkg::DATA_W-1:0] data_in,
	input  wire logic                       offset_load_select,
	// Read side
	input  wire logic                       read_enable_n,
	output var  logic [sfo_pkg::DATA_W-1:0] data_out,
	// Expansion control
	input  wire logic                       first_device_select,
	input  wire logic                       depth_chain_enable,
	input  wire logic                       write_chain_in_n,
	input  wire logic                       read_chain_in_n,
	// Flags and chain outputs
	output var  logic                       full_flag_n,
	output var  logic                       empty_flag_n,
	output var  logic                       almost_full_flag_n,
	output var  logic                       almost_empty_flag_n,
	output var  logic                       write_chain_out_half_full_n,
	output var  logic                       read_chain_out_n
);
	localparam int unsigned AW  = $clog2(DEPTH);
	localparam int unsigned CW  = AW + 1;
	localparam int unsigned DW  = sfo_pkg::DATA_W;
	localparam int unsigned OW  = sfo_pkg::OFS_W;
	localparam int unsigned XW  = (CW > OW) ? CW + 1 : OW + 1;
	localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);
	localparam logic [XW-1:0] DEPTH_X  = XW'(DEPTH);
	localparam logic [CW-1:0] HALF_C   = CW'(DEPTH / 2);
	localparam logic [OW-1:0] OFS_DEF  = sfo_pkg::default_offset(DEPTH);

	// Refuse depths the flag arithmetic cannot serve
	if (DEPTH < sfo_pkg::DEPTH_MIN || DEPTH > sfo_pkg::DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("sfo_fifo: DEPTH must be a power of two from 256 to 4096");
	end

	// Widen a threshold for comparison
	function automatic logic [XW-1:0] widen(input logic [OW-1:0] v);
		return XW'(v);
	endfunction : widen

	logic [OW-1:0]           ae_ofs_r;
	logic [OW-1:0]           af_ofs_r;
	sfo_pkg::sfo_ofs_sel_e   wsel_r;
	sfo_pkg::sfo_ofs_sel_e   rsel_r;
	logic [CW-1:0]           cnt_r;
	logic [CW-1:0]           cnt_nxt;
	logic [CW-1:0]           ram_cnt_r;
	logic [AW-1:0]           wptr_r;
	logic [AW-1:0]           rptr_r;
	logic                    wtok_r;
	logic                    rtok_r;
	logic                    started_r;
	logic                    inflight_r;
	logic                    inflight_last_r;
	logic [DW:0]             buf0_r;
	logic [DW:0]             buf1_r;
	logic [1:0]              buf_cnt_r;
	logic [1:0]              buf_cnt_nxt;
	logic [DW-1:0]           ram_rdata;
	logic                    wr_data;
	logic                    rd_data;
	logic                    ofs_wr;
	logic                    ofs_rd;
	logic                    pre_req;
	logic                    buf_push;
	logic                    wr_last;
	logic                    rd_last;

	// Request decode; load low steers both ports to the thresholds
	assign ofs_wr  = !write_enable_n && !offset_load_select;
	assign ofs_rd  = !read_enable_n && !offset_load_select;
	assign wr_data = !write_enable_n && offset_load_select && full_flag_n
		&& (!depth_chain_enable || wtok_r);
	assign rd_data = !read_enable_n && offset_load_select && (buf_cnt_r != 2'h0)
		&& (!depth_chain_enable || rtok_r);
	assign wr_last = wr_data && (wptr_r == LAST_LOC);
	assign rd_last = rd_data && buf0_r[DW];

	// Prefetch reserves buffer room before the memory answers, so a push always fits
	assign pre_req  = (ram_cnt_r != '0) && ({1'b0, buf_cnt_r} + {2'h0, inflight_r} < 3'(sfo_pkg::BUF_DEPTH));
	assign buf_push = inflight_r;

	// Stored word count after this edge
	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_data && !rd_data)
			cnt_nxt = cnt_r + 1'b1;
		else if (!wr_data && rd_data)
			cnt_nxt = cnt_r - 1'b1;
	end

	// Buffer occupancy after this edge
	always_comb begin
		buf_cnt_nxt = buf_cnt_r;
		if (buf_push && !rd_data)
			buf_cnt_nxt = buf_cnt_r + 1'b1;
		else if (!buf_push && rd_data)
			buf_cnt_nxt = buf_cnt_r - 1'b1;
	end

	// Memory array with registered read data
	sfo_ram #(
		.WIDTH (DW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_ram (
		.clock     (clock),
		.wr_en     (wr_data),
		.wr_addr   (wptr_r),
		.wr_data   (data_in),
		.rd_en     (pre_req),
		.rd_addr   (rptr_r),
		.rd_data_r (ram_rdata)
	);

	// Threshold registers and write-side selector
	always_ff @(posedge clock) begin
		if (rst) begin
			ae_ofs_r <= OFS_DEF;
			af_ofs_r <= OFS_DEF;
			wsel_r   <= sfo_pkg::SEL_EMPTY;
		end else if (ofs_wr) begin
			if (wsel_r == sfo_pkg::SEL_EMPTY)
				ae_ofs_r <= data_in[OW-1:0];
			else
				af_ofs_r <= data_in[OW-1:0];
			// Selector is kept across load phases, so loading resumes in sequence
			wsel_r <= (wsel_r == sfo_pkg::SEL_EMPTY) ? sfo_pkg::SEL_FULL : sfo_pkg::SEL_EMPTY;
		end
	end

	// Read-side selector, independent of the write selector
	always_ff @(posedge clock) begin
		if (rst)
			rsel_r <= sfo_pkg::SEL_EMPTY;
		else if (ofs_rd)
			rsel_r <= (rsel_r == sfo_pkg::SEL_EMPTY) ? sfo_pkg::SEL_FULL : sfo_pkg::SEL_EMPTY;
	end

	// Output data register: threshold readback or next stored word
	always_ff @(posedge clock) begin
		if (rst)
			data_out <= '0;
		else if (ofs_rd)
			data_out <= DW'(rsel_r == sfo_pkg::SEL_EMPTY ? ae_ofs_r : af_ofs_r);
		else if (rd_data)
			data_out <= buf0_r[DW-1:0];
	end

	// Write address and total count
	always_ff @(posedge clock) begin
		if (rst) begin
			wptr_r <= '0;
			cnt_r  <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			if (wr_data)
				wptr_r <= wptr_r + 1'b1;
		end
	end

	// Prefetch side: words still in memory, read address, word in flight
	always_ff @(posedge clock) begin
		if (rst) begin
			rptr_r          <= '0;
			ram_cnt_r       <= '0;
			inflight_r      <= 1'b0;
			inflight_last_r <= 1'b0;
		end else begin
			inflight_r      <= pre_req;
			inflight_last_r <= (rptr_r == LAST_LOC);
			if (pre_req)
				rptr_r <= rptr_r + 1'b1;
			if (wr_data && !pre_req)
				ram_cnt_r <= ram_cnt_r + 1'b1;
			else if (!wr_data && pre_req)
				ram_cnt_r <= ram_cnt_r - 1'b1;
		end
	end

	// Two-entry buffer; a stalled reader leaves words waiting here, none dropped
	always_ff @(posedge clock) begin
		if (rst) begin
			buf_cnt_r <= '0;
			buf0_r    <= '0;
			buf1_r    <= '0;
		end else begin
			buf_cnt_r <= buf_cnt_nxt;
			case ({buf_push, rd_data})
				2'b10: begin
					if (buf_cnt_r == 2'h0)
						buf0_r <= {inflight_last_r, ram_rdata};
					else
						buf1_r <= {inflight_last_r, ram_rdata};
				end
				2'b01: begin
					buf0_r <= buf1_r;
				end
				2'b11: begin
					if (buf_cnt_r == 2'h1) begin
						buf0_r <= {inflight_last_r, ram_rdata};
					end else begin
						buf0_r <= buf1_r;
						buf1_r <= {inflight_last_r, ram_rdata};
					end
				end
				default: begin
					buf0_r <= buf0_r;
				end
			endcase
		end
	end

	// Chain tokens; the head device starts owning both, caught after reset release
	always_ff @(posedge clock) begin
		if (rst) begin
			started_r <= 1'b0;
			wtok_r    <= 1'b0;
			rtok_r    <= 1'b0;
		end else if (!started_r) begin
			started_r <= 1'b1;
			wtok_r    <= !first_device_select;
			rtok_r    <= !first_device_select;
		end else if (depth_chain_enable) begin
			// Incoming token wins over giving ours away in the same cycle
			if (!write_chain_in_n)
				wtok_r <= 1'b1;
			else if (wr_last)
				wtok_r <= 1'b0;
			if (!read_chain_in_n)
				rtok_r <= 1'b1;
			else if (rd_last)
				rtok_r <= 1'b0;
		end
	end

	// Fixed flags: full from the count, empty from the buffer occupancy after this edge
	always_ff @(posedge clock) begin
		if (rst) begin
			full_flag_n  <= sfo_pkg::FULL_RST;
			empty_flag_n <= sfo_pkg::EMPTY_RST;
		end else begin
			full_flag_n  <= (widen(OW'(0)) + XW'(cnt_nxt)) != DEPTH_X;
			// Empty tracks the buffer so a read is only offered with a word in hand
			empty_flag_n <= (buf_cnt_nxt != 2'h0);
		end
	end

	// Programmable flags; single clock, so write and read edges coincide
	always_ff @(posedge clock) begin
		if (rst) begin
			almost_full_flag_n  <= sfo_pkg::AF_RST;
			almost_empty_flag_n <= sfo_pkg::AE_RST;
		end else begin
			almost_full_flag_n  <= (XW'(cnt_nxt) + widen(af_ofs_r)) < DEPTH_X;
			almost_empty_flag_n <= XW'(cnt_nxt) > widen(ae_ofs_r);
		end
	end

	// Shared output: half-full in single mode, write chain pulse in chain mode
	always_ff @(posedge clock) begin
		if (rst)
			write_chain_out_half_full_n <= sfo_pkg::HF_RST;
		else if (depth_chain_enable)
			write_chain_out_half_full_n <= !wr_last;
		else
			write_chain_out_half_full_n <= !(cnt_nxt > HALF_C);
	end

	// Read chain pulse when the last location leaves this device
	always_ff @(posedge clock) begin
		if (rst)
			read_chain_out_n <= sfo_pkg::XO_RST;
		else
			read_chain_out_n <= !(depth_chain_enable && rd_last);
	end
endmodule : sfo_fifo
`default_nettype wire

// ### hw/sfo_pkg.sv
`default_nettype none
package sfo_pkg;
	// Data path and offset widths
	localparam int unsigned DATA_W = 18;
	localparam int unsigned OFS_W  = 12;
	// Smallest and largest supported depth
	localparam int unsigned DEPTH_MIN = 256;
	localparam int unsigned DEPTH_MAX = 4096;
	// Output buffer between memory and data register
	localparam int unsigned BUF_DEPTH = 2;
	// Default thresholds per depth
	localparam logic [OFS_W-1:0] OFS_DEF_256  = 12'h01f;
	localparam logic [OFS_W-1:0] OFS_DEF_512  = 12'h03f;
	localparam logic [OFS_W-1:0] OFS_DEF_DEEP = 12'h07f;
	// Reset values of the flags (all active low)
	localparam logic FULL_RST  = 1'b1;
	localparam logic EMPTY_RST = 1'b0;
	localparam logic AF_RST    = 1'b1;
	localparam logic AE_RST    = 1'b0;
	localparam logic HF_RST    = 1'b1;
	localparam logic XO_RST    = 1'b1;

	// Offset register pointer; one bit, so the Gray path is trivial
	typedef enum logic {
		SEL_EMPTY = 1'b0,
		SEL_FULL  = 1'b1
	} sfo_ofs_sel_e;

	// Default threshold for a given depth
	function automatic logic [OFS_W-1:0] default_offset(input int unsigned depth);
		if (depth == 256)
			return OFS_DEF_256;
		else if (depth == 512)
			return OFS_DEF_512;
		else
			return OFS_DEF_DEEP;
	endfunction : default_offset
endpackage : sfo_pkg
`default_nettype wire

// ### hw/sfo_ram.sv
`default_nettype none
module sfo_ram #(
	parameter int unsigned WIDTH = 18,
	parameter int unsigned DEPTH = 256,
	parameter int unsigned AW    = 8
) (
	// Clock
	input  wire logic             clock,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port, data registered
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output var  logic [WIDTH-1:0] rd_data_r
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Storage array; no reset so it maps onto block memory
	always_ff @(posedge clock) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// Registered read port
	always_ff @(posedge clock) begin
		if (rd_en)
			rd_data_r <= mem[rd_addr];
	end
endmodule : sfo_ram
`default_nettype wire

// ### tb/sfo_fifo_monitor.sv
`default_nettype none
// Port-level checks of flags and threshold reads; one clock, so one default clocking
module sfo_fifo_monitor #(
	parameter int unsigned DEPTH = 256
) (
	// Clock and reset
	input wire logic                       clock,
	input wire logic                       rst,
	// Requests
	input wire logic                       write_enable_n,
	input wire logic [sfo_pkg::DATA_W-1:0] data_in,
	input wire logic                       offset_load_select,
	input wire logic                       read_enable_n,
	input wire logic [sfo_pkg::DATA_W-1:0] data_out,
	// Expansion straps
	input wire logic                       first_device_select,
	input wire logic                       depth_chain_enable,
	input wire logic                       write_chain_in_n,
	input wire logic                       read_chain_in_n,
	// Flags
	input wire logic                       full_flag_n,
	input wire logic                       empty_flag_n,
	input wire logic                       almost_full_flag_n,
	input wire logic                       almost_empty_flag_n,
	input wire logic                       write_chain_out_half_full_n,
	input wire logic                       read_chain_out_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// No data write this cycle; four of them cover the buffer fill latency
	sequence no_wr_s; write_enable_n || !offset_load_select; endsequence
	sequence quiet4_s; no_wr_s [*4]; endsequence
	// Load high long enough that a fresh threshold has settled into the flags
	sequence ld_hold_s; offset_load_select [*2]; endsequence

	full_hold_a: assert property (full_flag_n && (write_enable_n || !offset_load_select) |=> full_flag_n)
		else $error("full flag fell without a write");
	full_stuck_a: assert property (!full_flag_n && read_enable_n |=> !full_flag_n)
		else $error("full flag rose without a read");
	empty_hold_a: assert property (quiet4_s ##0 !empty_flag_n |=> !empty_flag_n)
		else $error("empty flag rose without a write");
	thr_read_a: assert property (!read_enable_n && !offset_load_select |=> data_out[17:12] == 6'h00)
		else $error("threshold read upper bits not zero");
	half_hold_a: assert property (write_chain_out_half_full_n && (write_enable_n || !offset_load_select)
		&& !depth_chain_enable
		|=> write_chain_out_half_full_n) else $error("half flag fell without a write");
	af_hold_a: assert property (ld_hold_s ##0 !almost_full_flag_n && read_enable_n |=> !almost_full_flag_n)
		else $error("almost full rose without a read");
	ae_hold_a: assert property (ld_hold_s ##0 (!almost_empty_flag_n && write_enable_n) |=> !almost_empty_flag_n)
		else $error("almost empty rose without a write");
	chain_idle_a: assert property (!depth_chain_enable |-> read_chain_out_n)
		else $error("read chain pulse in single mode");
	reset_out_a: assert property ($fell(rst) |-> data_out == '0 && !empty_flag_n && full_flag_n)
		else $error("outputs not cleared by reset");
endmodule : sfo_fifo_monitor
`default_nettype wire

// ### tb/sfo_host.sv
`default_nettype none
// Host model: one request at a time, so threshold reads and writes never overlap
module sfo_host (
	// Clock and status
	input  wire logic        clock,
	input  wire logic        empty_flag_n,
	// Request lines
	output var  logic        write_enable_n,
	output var  logic [17:0] data_in,
	output var  logic        offset_load_select,
	output var  logic        read_enable_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle lines at time zero
	initial begin
		write_enable_n = 1'b1;
		read_enable_n = 1'b1;
		offset_load_select = 1'b1;
		data_in = 18'h00000;
	end
	// One write cycle; en low keeps the enable high; released data is inverted
	task automatic wr(input logic [17:0] d, input logic ld, input logic en);
		@(posedge clock);
		#1;
		data_in = d;
		offset_load_select = ld;
		write_enable_n = !en;
		@(posedge clock);
		#1;
		write_enable_n = 1'b1;
		offset_load_select = 1'b1;
		data_in = ~d;
	endtask : wr
	// One read cycle; a data read first waits, bounded, for a ready word
	task automatic rd(input logic ld, output bit ok);
		int i;
		i = 0;
		@(posedge clock);
		#1;
		while (ld && empty_flag_n !== 1'b1 && i < 50) begin
			@(posedge clock);
			#1;
			i++;
		end
		ok = (i < 50);
		offset_load_select = ld;
		read_enable_n = !ok;
		@(posedge clock);
		#1;
		read_enable_n = 1'b1;
		offset_load_select = 1'b1;
	endtask : rd
endmodule : sfo_host
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned D = 256;
	logic        clock = 1'b0;
	logic        rst   = 1'b1;
	logic        write_enable_n, offset_load_select, read_enable_n;
	logic [17:0] data_in, data_out, d;
	logic        full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n;
	logic        write_chain_out_half_full_n, read_chain_out_n;
	logic [31:0] seed = 32'h000100b5;
	logic [17:0] q[$];
	int          failures = 0;
	int          n_tests = 0;
	int          c, n, m;
	bit          ok;
	// 100 MHz clock
	always #5 clock = ~clock;
	sfo_host host_i (.clock(clock), .empty_flag_n(empty_flag_n), .write_enable_n(write_enable_n),
		.data_in(data_in), .offset_load_select(offset_load_select), .read_enable_n(read_enable_n));
	// Chain straps tied to single mode: the chain path is not driven; the monitor only checks for no read chain pulse
	sfo_fifo #(.DEPTH(D)) sfo_fifo_i (.clock(clock), .rst(rst), .write_enable_n(write_enable_n),
		.data_in(data_in), .offset_load_select(offset_load_select), .read_enable_n(read_enable_n),
		.data_out(data_out), .first_device_select(1'b0), .depth_chain_enable(1'b0),
		.write_chain_in_n(1'b1), .read_chain_in_n(1'b1), .full_flag_n(full_flag_n),
		.empty_flag_n(empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
		.almost_empty_flag_n(almost_empty_flag_n), .write_chain_out_half_full_n(write_chain_out_half_full_n),
		.read_chain_out_n(read_chain_out_n));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Expected {full, almost full, almost empty, half} for word count c
	function automatic logic [3:0] exp_flags(int cnt);
		return {cnt != D, cnt + m < D, cnt > n, cnt <= D / 2};
	endfunction : exp_flags
	task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic flags();
		check({14'h0, full_flag_n, almost_full_flag_n, almost_empty_flag_n, write_chain_out_half_full_n},
			{14'h0, exp_flags(c)}, "flags");
	endtask : flags
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		#1;
		rst = 1'b0;
		check({12'h0, empty_flag_n, full_flag_n, almost_full_flag_n, almost_empty_flag_n,
			write_chain_out_half_full_n, read_chain_out_n}, 18'h0001b, "reset flags");
		host_i.rd(1'b0, ok);
		check(data_out, 18'h0001f, "default empty threshold");
		host_i.rd(1'b0, ok);
		check(data_out, 18'h0001f, "default full threshold");
		$display("test defaults done");
		n = xs() % 16;
		m = 1 + xs() % 16;
		host_i.wr(18'(xs()) & 18'h00fff, 1'b0, 1'b1);
		host_i.wr({6'h0, 12'(m)}, 1'b0, 1'b1);
		host_i.wr(18'h00fff, 1'b0, 1'b0);
		host_i.wr({6'h0, 12'(n)}, 1'b0, 1'b1);
		host_i.rd(1'b0, ok);
		check(data_out, {6'h0, 12'(n)}, "empty threshold");
		host_i.rd(1'b0, ok);
		check(data_out, {6'h0, 12'(m)}, "full threshold");
		host_i.rd(1'b0, ok);
		check(data_out, {6'h0, 12'(n)}, "read pointer wrap");
		$display("test thresholds done");
		c = 0;
		for (int i = 0; i <= D; i++) begin
			d = 18'(xs());
			host_i.wr(d, 1'b1, 1'b1);
			if (c < D) begin
				q.push_back(d);
				c++;
			end
			flags();
			if (i == 2)
				check({17'h0, empty_flag_n}, 18'h00001, "empty after writes");
		end
		$display("test fill done");
		while (c > 0) begin
			repeat (xs() % 3) @(posedge clock);
			host_i.rd(1'b1, ok);
			if (!ok) begin
				failures++;
				end_of_test();
			end
			check(data_out, q.pop_front(), "data order");
			c--;
			flags();
		end
		check({17'h0, empty_flag_n}, 18'h00000, "empty after drain");
		$display("test drain done");
		end_of_test();
	end
endmodule : tb_top
bind sfo_fifo sfo_fifo_monitor #(.DEPTH(DEPTH)) mon_i (.clock(clock), .rst(rst),
	.write_enable_n(write_enable_n), .data_in(data_in), .offset_load_select(offset_load_select),
	.read_enable_n(read_enable_n), .data_out(data_out), .first_device_select(first_device_select),
	.depth_chain_enable(depth_chain_enable), .write_chain_in_n(write_chain_in_n),
	.read_chain_in_n(read_chain_in_n), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
	.almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
	.write_chain_out_half_full_n(write_chain_out_half_full_n), .read_chain_out_n(read_chain_out_n));
`default_nettype wire
